// ===== scl_pkg.sv
// constants for the strap loader and management register block
// assumes a single 10 MHz clock and a slow management clock on a pin
package scl_pkg;

  // ****************************************************************
  // clock and strap timing
  // ****************************************************************
  localparam int CLK_HZ = 10_000_000;
  localparam int STRAP_SETTLE_NS = 300;
  localparam int STRAP_SETTLE_CYC =
    (STRAP_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [3:0] SETTLE_LAST = 4'(STRAP_SETTLE_CYC);

  // ****************************************************************
  // register indices
  // ****************************************************************
  localparam logic [4:0] IDX_BASIC_CONTROL = 5'h00;
  localparam logic [4:0] IDX_BASIC_STATUS = 5'h01;
  localparam logic [4:0] IDX_IDENTITY_WORD_1 = 5'h02;
  localparam logic [4:0] IDX_IDENTITY_WORD_2 = 5'h03;
  localparam logic [4:0] IDX_EXTENDED_STATUS = 5'h0F;
  localparam logic [4:0] IDX_IDENTITY_WORD_3 = 5'h10;
  localparam logic [4:0] IDX_EXTENDED_CONTROL = 5'h11;
  localparam logic [4:0] IDX_PORT_CONFIG_ONE = 5'h12;
  localparam logic [4:0] IDX_PORT_CONFIG_TWO = 5'h13;
  localparam logic [4:0] IDX_SYMBOL_ERROR_COUNT = 5'h14;
  localparam logic [4:0] IDX_EVENT_SOURCE = 5'h15;
  localparam logic [4:0] IDX_EVENT_ENABLE = 5'h16;
  localparam logic [4:0] IDX_LINK_COMM_STATUS = 5'h17;
  localparam logic [4:0] IDX_GENERAL_STATUS = 5'h18;
  localparam logic [4:0] IDX_EXTERNAL_STATUS = 5'h19;
  localparam logic [4:0] IDX_LINK_FAIL_COUNT = 5'h1A;
  localparam logic [4:0] IDX_SHARED_CONFIG = 5'h1B;
  localparam logic [4:0] IDX_PORT_CONFIG_THREE = 5'h1C;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_SOFT_RESET = 15;
  localparam int CTRL_LOOPBACK = 14;
  localparam int CTRL_POWER_DOWN = 11;
  localparam int CTRL_ISOLATE = 10;
  localparam int CTRL_UNIDIRECT = 5;
  localparam logic [15:0] CTRL_WR_MASK = 16'hCC20;
  localparam logic [15:0] CTRL_FIXED_ONES = 16'h2100;
  localparam int STAT_LINK_UP = 2;
  localparam logic [15:0] STAT_FIXED_ONES = 16'h0101;
  localparam int CFG1_MASTER = 15;
  localparam int CFG1_AUTONOMOUS = 14;
  localparam int CFG1_MII_MODE_LO = 8;
  localparam int CFG1_PORT_ENABLE = 1;
  localparam int SHR_CLK_MODE_LO = 12;
  localparam int SHR_EXT_SUPPLY = 11;
  localparam int EXT_INT_REV = 15;
  localparam int EVT_LINK_FAIL = 0;

  // ****************************************************************
  // reset values and codes
  // ****************************************************************
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] ZERO_RESET = 16'h0000;
  localparam logic [1:0] MII_MODE_MII = 2'h0;
  localparam logic [1:0] MII_MODE_RMII_25 = 2'h1;
  localparam logic [1:0] MII_MODE_RMII_50 = 2'h2;
  localparam logic [1:0] MII_MODE_REV = 2'h3;
  localparam logic [1:0] IFC_MII = 2'h0;
  localparam logic [1:0] IFC_RMII = 2'h1;
  localparam logic [1:0] IFC_REV_INT = 2'h2;
  localparam logic [1:0] CLK_REF_50 = 2'h3;
  localparam logic [5:0] PREAMBLE_ONES = 6'h20;
  localparam logic [1:0] FRAME_START = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;

  typedef enum logic [3:0] {
    SCL_PRE = 4'h1,
    SCL_HDR = 4'h2,
    SCL_TA = 4'h4,
    SCL_DATA = 4'h8
  } scl_frame_t;

endpackage

// ===== scl_strap_loader.sv
// strap sampling and management register set for a two-port phy
// assumes straps and the management clock and data arrive as pins,
// and that link events come from logic on the same clock
`timescale 1ns/1ps

// ****************************************************************
// What this block does
// ****************************************************************

module scl_strap_loader
  import scl_pkg::*;
#(
  parameter bit SINGLE_PORT = 1'b0,
  parameter logic [15:0] IDENT_ONE = 16'h0123,   // arbitrary value
  parameter logic [15:0] IDENT_TWO = 16'h4560,   // arbitrary value
  parameter logic [15:0] IDENT_THREE = 16'h0007  // arbitrary value
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] strap_pin,
  input wire logic [3:1] port_address_strap,
  input wire logic core_supply_select_pin,
  input wire logic mdc,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  input wire logic [1:0] link_up,
  input wire logic [1:0] link_fail_evt,
  output logic strap_loaded,
  output logic [3:0] port_base_address,
  output logic [1:0] port_enable,
  output logic [1:0] port_master,
  output logic [1:0] port_loopback,
  output logic [1:0] mii_mode_zero,
  output logic [1:0] mii_mode_one,
  output logic [1:0] clk_mode,
  output logic core_regulator_internal,
  output logic autonomous_operation,
  output logic internal_reverse
);

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  logic [13:0] pin_s1;
  logic [13:0] pin_s2;
  logic mdc_s1, mdc_s2, mdc_s3;
  logic mdio_s1, mdio_s2;

  always_ff @(posedge clk) begin
    pin_s1 <= {core_supply_select_pin, port_address_strap, strap_pin,
               2'h0};
    pin_s2 <= pin_s1;
    mdc_s1 <= mdc;
    mdc_s2 <= mdc_s1;
    mdc_s3 <= mdc_s2;
    mdio_s1 <= mdio_in;
    mdio_s2 <= mdio_s1;
  end

  wire mdc_rise = mdc_s2 & ~mdc_s3;
  // pin level is taken as is: pull-up reads 1, pull-down reads 0
  wire [7:0] strap_now = pin_s2[9:2];
  wire [3:1] addr_now = pin_s2[12:10];
  wire ext_supply_now = pin_s2[13];

  // ****************************************************************
  // strap decoding
  // ****************************************************************
  // role pins: strap_pin_3 msb, strap_pin_2, strap_pin_1 lsb
  function automatic logic [3:0] f_role(input logic [2:0] role);
    logic [3:0] r;  // {en1, master1, en0, master0}
    r = 4'h0;
    r[1] = (role != 3'h0) && (role != 3'h1);
    r[0] = (role == 3'h2) || (role == 3'h3) || (role == 3'h4);
    r[3] = (role != 3'h2) && (role != 3'h5) && !SINGLE_PORT;
    r[2] = ((role == 3'h0) || (role == 3'h3) || (role == 3'h6)) &&
           !SINGLE_PORT;
    return r;
  endfunction

  function automatic logic [15:0] f_cfg1(input logic [7:0] s,
                                         input logic p);
    logic [15:0] v;
    logic [3:0] role;
    logic [1:0] ifc;
    logic [1:0] cm;
    v = ZERO_RESET;
    role = f_role({s[3], s[2], s[1]});
    ifc = {s[5], s[4]};
    cm = {s[7], s[6]};
    v[CFG1_PORT_ENABLE] = p ? role[3] : role[1];
    v[CFG1_MASTER] = p ? role[2] : role[0];
    v[CFG1_AUTONOMOUS] = s[0];
    case (ifc)
      IFC_MII: v[CFG1_MII_MODE_LO +: 2] = MII_MODE_MII;
      IFC_RMII: v[CFG1_MII_MODE_LO +: 2] =
        (cm == CLK_REF_50) ? MII_MODE_RMII_50 : MII_MODE_RMII_25;
      default: v[CFG1_MII_MODE_LO +: 2] =
        p ? MII_MODE_MII : MII_MODE_REV;
    endcase
    return v;
  endfunction

  // ****************************************************************
  // strap load sequencing
  // ****************************************************************
  logic [3:0] settle_cnt;
  logic load_all;
  logic [1:0] soft_rst;

  always_ff @(posedge clk) begin
    if (srst) begin
      settle_cnt <= 4'h0;
      strap_loaded <= 1'b0;
      load_all <= 1'b0;
    end else begin
      load_all <= 1'b0;
      // the synchronisers must fill before the pins are trusted
      if (!strap_loaded) begin
        if (settle_cnt == SETTLE_LAST) begin
          strap_loaded <= 1'b1;
          load_all <= 1'b1;
        end else begin
          settle_cnt <= settle_cnt + 4'h1;
        end
      end
    end
  end

  // address is taken only on the first load, never on soft reset
  always_ff @(posedge clk) begin
    if (srst) begin
      port_base_address <= 4'h0;
    end else if (load_all) begin
      port_base_address <= {addr_now, 1'b0};
    end
  end

  // ****************************************************************
  // management frame engine
  // ****************************************************************
  scl_frame_t state;
  logic [5:0] ones_cnt;
  logic [4:0] bit_cnt;
  logic [12:0] hdr_sh;
  logic [15:0] shift;
  logic is_read;
  logic cur_port;
  logic [4:0] cur_idx;
  logic wr_pulse;
  logic rd_pulse;
  logic [15:0] rdata;

  wire [13:0] hdr_full = {hdr_sh, mdio_s2};
  wire [4:0] frame_addr = hdr_full[9:5];
  // bit four of the frame address is always zero for this device
  wire addr_hit_base = frame_addr[4:1] == {1'b0, port_base_address[3:1]};
  wire addr_zero = frame_addr == 5'h00;
  // address zero is served by port zero
  wire frame_port = addr_zero ? 1'b0 : frame_addr[0];
  wire addr_ok = addr_zero ||
                 (addr_hit_base && !(SINGLE_PORT && frame_addr[0]));
  wire op_ok = (hdr_full[11:10] == OP_READ) ||
               (hdr_full[11:10] == OP_WRITE);

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= SCL_PRE;
      ones_cnt <= 6'h0;
      bit_cnt <= 5'h0;
      hdr_sh <= 13'h0;
      shift <= 16'h0000;
      is_read <= 1'b0;
      cur_port <= 1'b0;
      cur_idx <= 5'h00;
      wr_pulse <= 1'b0;
      rd_pulse <= 1'b0;
      mdio_out <= 1'b1;
      mdio_oe_n <= 1'b1;
    end else begin
      wr_pulse <= 1'b0;
      rd_pulse <= 1'b0;
      if (mdc_rise) begin
        case (state)
          SCL_PRE: begin
            if (mdio_s2) begin
              if (ones_cnt != PREAMBLE_ONES) begin
                ones_cnt <= ones_cnt + 6'h1;
              end
            end else if (ones_cnt == PREAMBLE_ONES) begin
              state <= SCL_HDR;
              hdr_sh <= 13'h0;
              bit_cnt <= 5'h1;
            end else begin
              ones_cnt <= 6'h0;
            end
          end
          SCL_HDR: begin
            hdr_sh <= hdr_full[12:0];
            bit_cnt <= bit_cnt + 5'h1;
            if (bit_cnt == 5'hD) begin
              ones_cnt <= 6'h0;
              bit_cnt <= 5'h0;
              if (hdr_full[13:12] == FRAME_START && op_ok && addr_ok) begin
                state <= SCL_TA;
                is_read <= hdr_full[11:10] == OP_READ;
                cur_port <= frame_port;
                cur_idx <= hdr_full[4:0];
              end else begin
                state <= SCL_PRE;
              end
            end
          end
          SCL_TA: begin
            bit_cnt <= bit_cnt + 5'h1;
            if (bit_cnt == 5'h1) begin
              state <= SCL_DATA;
              bit_cnt <= 5'h0;
              if (is_read) begin
                mdio_out <= 1'b0;
                mdio_oe_n <= 1'b0;
                shift <= rdata;
                rd_pulse <= 1'b1;
              end
            end
          end
          SCL_DATA: begin
            bit_cnt <= bit_cnt + 5'h1;
            if (is_read) begin
              if (bit_cnt == 5'h10) begin
                mdio_oe_n <= 1'b1;
                mdio_out <= 1'b1;
                state <= SCL_PRE;
              end else begin
                mdio_out <= shift[15];
                shift <= {shift[14:0], 1'b0};
              end
            end else begin
              shift <= {shift[14:0], mdio_s2};
              if (bit_cnt == 5'hF) begin
                wr_pulse <= 1'b1;
                state <= SCL_PRE;
              end
            end
          end
          default: begin
            state <= SCL_PRE;
            mdio_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // per-port register sets
  // ****************************************************************
  logic [15:0] ctrl [2];
  logic [15:0] ext_ctrl [2];
  logic [15:0] cfg1 [2];
  logic [15:0] cfg2 [2];
  logic [15:0] cfg3 [2];
  logic [15:0] evt_en [2];
  logic [15:0] evt_src [2];
  logic [15:0] fail_cnt [2];
  logic [1:0] link_seen;
  logic [15:0] shared;
  logic ext_supply;

  wire [15:0] wdata = shift;

  function automatic logic wr_hit(input logic p, input logic [4:0] idx,
                                  input logic go, input logic cp,
                                  input logic [4:0] ci);
    return go && (cp == p) && (ci == idx);
  endfunction

  always_ff @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (srst) begin
        ctrl[p] <= CTRL_RESET;
        ext_ctrl[p] <= ZERO_RESET;
        cfg1[p] <= ZERO_RESET;
        cfg2[p] <= ZERO_RESET;
        cfg3[p] <= ZERO_RESET;
        evt_en[p] <= ZERO_RESET;
        soft_rst[p] <= 1'b0;
      end else if (load_all || soft_rst[p]) begin
        ctrl[p] <= CTRL_RESET;
        ext_ctrl[p] <= ZERO_RESET;
        cfg1[p] <= f_cfg1(strap_now, p[0]);
        cfg2[p] <= ZERO_RESET;
        cfg3[p] <= ZERO_RESET;
        evt_en[p] <= ZERO_RESET;
        soft_rst[p] <= 1'b0;
      end else begin
        if (wr_hit(p[0], IDX_BASIC_CONTROL, wr_pulse, cur_port,
                   cur_idx)) begin
          ctrl[p] <= wdata & CTRL_WR_MASK;
          soft_rst[p] <= wdata[CTRL_SOFT_RESET];
        end
        if (wr_hit(p[0], IDX_EXTENDED_CONTROL, wr_pulse, cur_port,
                   cur_idx)) begin
          ext_ctrl[p] <= wdata;
        end
        if (wr_hit(p[0], IDX_PORT_CONFIG_ONE, wr_pulse, cur_port,
                   cur_idx)) begin
          // the single variant can never enable its second port
          cfg1[p] <= wdata;
          if (SINGLE_PORT && p == 1) begin
            cfg1[p][CFG1_PORT_ENABLE] <= 1'b0;
            cfg1[p][CFG1_MASTER] <= 1'b0;
          end
        end
        if (wr_hit(p[0], IDX_PORT_CONFIG_TWO, wr_pulse, cur_port,
                   cur_idx)) begin
          cfg2[p] <= wdata;
        end
        if (wr_hit(p[0], IDX_PORT_CONFIG_THREE, wr_pulse, cur_port,
                   cur_idx)) begin
          cfg3[p] <= wdata;
        end
        if (wr_hit(p[0], IDX_EVENT_ENABLE, wr_pulse, cur_port,
                   cur_idx)) begin
          evt_en[p] <= wdata;
        end
      end
    end
  end

  // shared registers live once and answer only through port zero
  always_ff @(posedge clk) begin
    if (srst) begin
      shared <= ZERO_RESET;
      ext_supply <= 1'b0;
      internal_reverse <= 1'b0;
    end else if (load_all || soft_rst[0]) begin
      shared <= ZERO_RESET;
      shared[SHR_CLK_MODE_LO +: 2] <= {strap_now[7], strap_now[6]};
      shared[SHR_EXT_SUPPLY] <= ext_supply_now;
      ext_supply <= ext_supply_now;
      internal_reverse <= {strap_now[5], strap_now[4]} == IFC_REV_INT;
    end else if (wr_hit(1'b0, IDX_SHARED_CONFIG, wr_pulse, cur_port,
                        cur_idx)) begin
      shared <= wdata;
      ext_supply <= wdata[SHR_EXT_SUPPLY];
    end
  end

  // ****************************************************************
  // latched status and read-cleared counters
  // ****************************************************************
  always_ff @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (srst) begin
        evt_src[p] <= ZERO_RESET;
        fail_cnt[p] <= ZERO_RESET;
        link_seen[p] <= 1'b0;
      end else begin
        // a fresh event beats a read-clear in the same cycle
        if (link_fail_evt[p]) begin
          evt_src[p][EVT_LINK_FAIL] <= 1'b1;
        end else if (wr_hit(p[0], IDX_EVENT_SOURCE, rd_pulse, cur_port,
                            cur_idx)) begin
          evt_src[p] <= ZERO_RESET;
        end
        if (wr_hit(p[0], IDX_LINK_FAIL_COUNT, rd_pulse, cur_port,
                   cur_idx)) begin
          fail_cnt[p] <= {15'h0000, link_fail_evt[p]};
        end else if (link_fail_evt[p] && fail_cnt[p] != 16'hFFFF) begin
          fail_cnt[p] <= fail_cnt[p] + 16'h0001;
        end
        // link drop sticks low until read, then follows the link again
        if (!link_up[p]) begin
          link_seen[p] <= 1'b0;
        end else if (wr_hit(p[0], IDX_BASIC_STATUS, rd_pulse, cur_port,
                            cur_idx)) begin
          link_seen[p] <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  always_comb begin
    logic p0;
    p0 = !cur_port;
    rdata = 16'h0000;
    case (cur_idx)
      IDX_BASIC_CONTROL: begin
        rdata = ctrl[cur_port] | CTRL_FIXED_ONES;
        rdata[CTRL_SOFT_RESET] = soft_rst[cur_port];
      end
      IDX_BASIC_STATUS: begin
        rdata = STAT_FIXED_ONES;
        rdata[STAT_LINK_UP] = link_seen[cur_port];
      end
      IDX_IDENTITY_WORD_1: rdata = p0 ? IDENT_ONE : 16'h0000;
      IDX_IDENTITY_WORD_2: rdata = p0 ? IDENT_TWO : 16'h0000;
      IDX_EXTENDED_STATUS: rdata = 16'h0000;
      IDX_IDENTITY_WORD_3: rdata = p0 ? IDENT_THREE : 16'h0000;
      IDX_EXTENDED_CONTROL: rdata = ext_ctrl[cur_port];
      IDX_PORT_CONFIG_ONE: rdata = cfg1[cur_port];
      IDX_PORT_CONFIG_TWO: rdata = cfg2[cur_port];
      IDX_SYMBOL_ERROR_COUNT: rdata = 16'h0000;
      IDX_EVENT_SOURCE: rdata = evt_src[cur_port];
      IDX_EVENT_ENABLE: rdata = evt_en[cur_port];
      IDX_LINK_COMM_STATUS: rdata = 16'h0000;
      IDX_GENERAL_STATUS: rdata = 16'h0000;
      IDX_EXTERNAL_STATUS: begin
        rdata = 16'h0000;
        rdata[EXT_INT_REV] = p0 & internal_reverse;
      end
      IDX_LINK_FAIL_COUNT: rdata = fail_cnt[cur_port];
      IDX_SHARED_CONFIG: rdata = p0 ? shared : 16'h0000;
      IDX_PORT_CONFIG_THREE: rdata = cfg3[cur_port];
      default: rdata = 16'h0000;
    endcase
  end

  // ****************************************************************
  // configuration outputs
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      port_enable <= 2'h0;
      port_master <= 2'h0;
      port_loopback <= 2'h0;
      mii_mode_zero <= MII_MODE_MII;
      mii_mode_one <= MII_MODE_MII;
      clk_mode <= 2'h0;
      core_regulator_internal <= 1'b1;
      autonomous_operation <= 1'b0;
    end else begin
      port_enable <= {cfg1[1][CFG1_PORT_ENABLE] & !SINGLE_PORT,
                      cfg1[0][CFG1_PORT_ENABLE]};
      port_master <= {cfg1[1][CFG1_MASTER], cfg1[0][CFG1_MASTER]};
      port_loopback <= {ctrl[1][CTRL_LOOPBACK], ctrl[0][CTRL_LOOPBACK]};
      mii_mode_zero <= cfg1[0][CFG1_MII_MODE_LO +: 2];
      mii_mode_one <= cfg1[1][CFG1_MII_MODE_LO +: 2];
      clk_mode <= shared[SHR_CLK_MODE_LO +: 2];
      core_regulator_internal <= !ext_supply;
      autonomous_operation <= cfg1[0][CFG1_AUTONOMOUS];
    end
  end

endmodule

// ===== scl_strap_loader_chk.sv
// assertions on strap loading and the management pin
// assumes it is bound onto scl_strap_loader with default parameters
`timescale 1ns/1ps
module scl_strap_loader_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] strap_pin,
  input wire logic core_supply_select_pin,
  input wire logic mdio_out,
  input wire logic mdio_oe_n,
  input wire logic strap_loaded,
  input wire logic [3:0] port_base_address,
  input wire logic [1:0] port_enable,
  input wire logic [1:0] port_master,
  input wire logic [1:0] mii_mode_zero,
  input wire logic [1:0] mii_mode_one,
  input wire logic internal_reverse,
  input wire logic core_regulator_internal
);
  // ****
  // decode of the present straps
  // ****
  logic [2:0] r;
  logic [1:0] mz;
  assign r = strap_pin[3:1];
  // the 50 MHz field only with rmii and the reference clock code
  assign mz = strap_pin[5] ? 2'h3 : !strap_pin[4] ? 2'h0 :
    strap_pin[7:6] == 2'h3 ? 2'h2 : 2'h1;
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  load_time_a: assert property (
    $fell(srst) |-> !strap_loaded [*4] ##1 strap_loaded)
    else $error("straps late");
  role_enable_a: assert property (
    $rose(strap_loaded) |-> ##2
    port_enable == {!(r inside {3'h2, 3'h5}), r > 3'h1})
    else $error("enable decode");
  role_master_a: assert property (
    $rose(strap_loaded) |-> ##2 port_master ==
    {r inside {3'h0, 3'h3, 3'h6}, r inside {3'h2, 3'h3, 3'h4}})
    else $error("master decode");
  mii_decode_a: assert property (
    $rose(strap_loaded) |-> ##2 mii_mode_zero == mz &&
    mii_mode_one == (strap_pin[5:4] == 2'h1 ? mz : 2'h0))
    else $error("mii decode");
  reverse_flag_a: assert property (
    $rose(strap_loaded) |-> ##2 internal_reverse == (strap_pin[5:4] == 2'h2))
    else $error("reverse flag");
  regulator_pick_a: assert property (
    $rose(strap_loaded) |-> ##2
    core_regulator_internal != core_supply_select_pin)
    else $error("regulator pick");
  address_hold_a: assert property (
    strap_loaded && $past(strap_loaded, 2) |-> $stable(port_base_address))
    else $error("address moved");
  drive_window_a: assert property (
    $fell(mdio_oe_n) |-> (!mdio_oe_n && !mdio_out) [*8])
    else $error("turnaround bit");
endmodule

bind scl_strap_loader scl_strap_loader_chk chk (.clk, .srst, .strap_pin,
  .core_supply_select_pin, .mdio_out, .mdio_oe_n, .strap_loaded,
  .port_base_address, .port_enable, .port_master, .mii_mode_zero,
  .mii_mode_one, .internal_reverse, .core_regulator_internal);

// ===== scl_smc_model.sv
// station management controller on the management pin
// assumes the pin has a pull-up; mdc stands low between frames
`timescale 1ns/1ps
module scl_smc_model (
  input wire logic clk,
  input wire logic mdio_out,
  input wire logic mdio_oe_n,
  output logic mdc,
  output logic mdio_in
);
  logic oe = 1'b0;
  logic dat = 1'b1;
  initial mdc = 1'b0;
  // pull-up wins when neither side drives
  assign mdio_in = !mdio_oe_n ? mdio_out : (oe ? dat : 1'b1);
  // ****
  // one bit per mdc period, sampled just before the rise
  // ****
  task automatic bit_cyc(input logic en, input logic d, output logic s);
    @(posedge clk);
    #1;
    mdc = 1'b0;
    oe = en;
    dat = d;
    repeat (5) @(posedge clk);
    #1;
    s = mdio_in;
    mdc = 1'b1;
    repeat (5) @(posedge clk);
  endtask
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa,
      input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
    logic [13:0] hdr;
    logic s;
    logic w;
    hdr = {2'h1, op, pa, ra};
    w = op == 2'h1;
    for (int i = 0; i < 32; i++) bit_cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) bit_cyc(1'b1, hdr[i], s);
    bit_cyc(w, 1'b1, s);
    bit_cyc(w, 1'b0, s);
    // each sample holds the bit driven after the previous rise
    for (int i = 16; i >= 0; i--) begin
      bit_cyc(w && i > 0, wd[i[3:0] - 4'h1], s);
      rd = {rd[14:0], s};
    end
    @(posedge clk);
    #1;
    mdc = 1'b0;
    oe = 1'b0;
  endtask
endmodule

// ===== scl_tb.sv
// self-checking bench for the strap loader and its register set
// assumes scl_smc_model stands on the management pin
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] ID1 = 16'h0123; // arbitrary value
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] strap_pin = 8'h00;
  logic [3:1] port_address_strap = 3'h0;
  logic core_supply_select_pin = 1'b0;
  logic [1:0] link_up = 2'h3;
  logic [1:0] link_fail_evt = 2'h0;
  logic mdc, mdio_in, mdio_out, mdio_oe_n, strap_loaded, internal_reverse;
  logic core_regulator_internal, autonomous_operation;
  logic [3:0] port_base_address;
  logic [1:0] port_enable, port_master, port_loopback;
  logic [1:0] mii_mode_zero, mii_mode_one, clk_mode;
  logic [15:0] rd;
  logic [2:0] i;
  int bad_count = 0;
  int n_tests = 0;
  always #50 clk = ~clk;
  scl_strap_loader #(.IDENT_ONE(ID1)) dut (.clk, .srst, .strap_pin,
    .port_address_strap, .core_supply_select_pin, .mdc, .mdio_in,
    .mdio_out, .mdio_oe_n, .link_up, .link_fail_evt, .strap_loaded,
    .port_base_address, .port_enable, .port_master, .port_loopback,
    .mii_mode_zero, .mii_mode_one, .clk_mode, .core_regulator_internal,
    .autonomous_operation, .internal_reverse);
  scl_smc_model smc (.clk, .mdio_out, .mdio_oe_n, .mdc, .mdio_in);
  // ****
  // access tasks and expectations
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [4:0] pa, input logic [4:0] ra,
      input logic [15:0] m, input logic [15:0] e);
    smc.xfer(2'h2, pa, ra, 16'h0000, rd);
    chk({16'h0, rd & m}, {16'h0, e});
  endtask
  task automatic wr(input logic [4:0] pa, input logic [4:0] ra,
      input logic [15:0] d);
    smc.xfer(2'h1, pa, ra, d, rd);
  endtask
  task automatic pulse(input logic lf);
    @(posedge clk);
    #1;
    link_up = lf ? 2'h3 : 2'h2;
    link_fail_evt = {1'b0, lf};
    @(posedge clk);
    #1;
    link_up = 2'h3;
    link_fail_evt = 2'h0;
  endtask
  task automatic boot();
    @(posedge clk);
    #1;
    srst = 1'b1;
    strap_pin = {i[2], i[0], i[1:0], i, i[0]};
    port_address_strap = i;
    core_supply_select_pin = i[1];
    repeat (4) @(posedge clk);
    #1;
    srst = 1'b0;
    for (int k = 0; k < 40 && strap_loaded !== 1'b1; k++) @(posedge clk);
    repeat (2) @(posedge clk);
    #1;
  endtask
  function automatic logic [31:0] exp_cfg();
    logic [1:0] mz;
    mz = i[1] ? 2'h3 : !i[0] ? 2'h0 : i[2] ? 2'h2 : 2'h1;
    return {15'h0, !(i inside {3'h2, 3'h5}), i > 3'h1,
      i inside {3'h0, 3'h3, 3'h6}, i inside {3'h2, 3'h3, 3'h4}, mz,
      i[1:0] == 2'h1 ? mz : 2'h0, i[2], i[0], i[1:0] == 2'h2, !i[1],
      i[0], i, 1'b0};
  endfunction
  task automatic print_verdict();
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial begin
    // the last code, 110, leaves base address 0xC for the register tests
    for (int j = 0; j < 8; j++) begin
      i = 3'(j ^ 1);
      boot();
      chk({15'h0, port_enable, port_master, mii_mode_zero, mii_mode_one,
        clk_mode, internal_reverse, core_regulator_internal,
        autonomous_operation, port_base_address}, exp_cfg());
    end
    rdchk(5'h0C, 5'h02, 16'hFFFF, ID1);
    rdchk(5'h00, 5'h02, 16'hFFFF, ID1);
    rdchk(5'h0D, 5'h02, 16'hFFFF, 16'h0000);
    rdchk(5'h0C, 5'h05, 16'hFFFF, 16'h0000);
    rdchk(5'h0A, 5'h02, 16'hFFFF, 16'hFFFF);
    rdchk(5'h0C, 5'h19, 16'h8000, 16'h8000);
    rdchk(5'h0D, 5'h19, 16'h8000, 16'h0000);
    rdchk(5'h0C, 5'h01, 16'hFFFF, 16'h0101);
    rdchk(5'h0C, 5'h01, 16'hFFFF, 16'h0105);
    pulse(1'b0);
    rdchk(5'h0C, 5'h01, 16'hFFFF, 16'h0101);
    rdchk(5'h0C, 5'h01, 16'hFFFF, 16'h0105);
    pulse(1'b1);
    rdchk(5'h0C, 5'h15, 16'h0001, 16'h0001);
    rdchk(5'h0C, 5'h15, 16'h0001, 16'h0000);
    wr(5'h0C, 5'h12, 16'h8302);
    rdchk(5'h0C, 5'h12, 16'hC302, 16'h8302);
    wr(5'h0D, 5'h12, 16'h0002);
    chk({port_base_address, port_master}, {4'hC, 2'h1});
    wr(5'h0C, 5'h00, 16'h8000);
    chk({port_base_address, port_master}, {4'hC, 2'h0});
    rdchk(5'h0C, 5'h00, 16'hFFFF, 16'h2100);
    wr(5'h0C, 5'h00, 16'h4000);
    chk({30'h0, port_loopback}, 32'h1);
    print_verdict();
  end
  initial begin
    #3_000_000;
    bad_count++;
    print_verdict();
  end
endmodule
